// file: rtl/port_alt_function_override.sv
/*
  Top of the port A alternate-function override block, with the routing
  of port B alternate inputs to their peripherals.
  Assumes all pin and peripheral inputs are synchronous to CORE_CLK and
  that the pad merges PA_OUT and PA_OE into the wire level.
*/
// Overview of operation
// - Port A bits are pin-change group 0 sources.
// - Port B bits 0-3 are group 1 sources.
// - Input enable override from pin change or disable.
// - Two-wire enable makes bit 7 open-drain clock.
// - Spike filter between bit 7 pad and two-wire.
// - Bit 7 value override for two-wire, master, compare.
// - Bit 7 outputs low for two-wire, else SPI clock, else compare B.
// - SPI slave forces bit 7 to input unless two-wire is enabled.
// - SPI master leaves bit 7 direction to register unless two-wire is enabled.
// - SPI slave forces bit 6 to input.
// - SPI master leaves bit 6 direction to register.
// - Bit 7 input feeds timer 1, SPI, two-wire, pin-change.
// - Bits 1 and 2 serve converter and comparator.
// - Port B bit 0 carries clock inputs.
// - Port B bits 1-3 carry data, interrupt, reset.
// - Direction override sets the driver enable.
// - Value override sets the pin value.
`timescale 1ns/10ps
module port_alt_function_override (
  input wire logic CORE_CLK,
  input wire logic RST,
  // Generic port A register bits and core state.
  input wire logic [paf_pkg::PA_W-1:0] PORTA_DIR,
  input wire logic [paf_pkg::PA_W-1:0] PORTA_OUT_REG,
  input wire logic [paf_pkg::PA_W-1:0] PORTA_PULLUP_REG,
  input wire logic [paf_pkg::PA_W-1:0] PORTA_NORMAL_DIG_IN_EN,
  // Port A pads, split into input, output and output enable.
  input wire logic [paf_pkg::PA_W-1:0] PA_IN,
  output logic [paf_pkg::PA_W-1:0] PA_OUT,
  output logic [paf_pkg::PA_W-1:0] PA_OE,
  output logic [paf_pkg::PA_W-1:0] PA_PULLUP_EN,
  output logic [paf_pkg::PA_W-1:0] PA_DIG_IN_EN,
  output logic PA7_SLEW_LIMIT_EN,
  output logic PA7_SPIKE_FILT_EN,
  // Peripheral controls.
  input wire logic TWO_WIRE_ENABLE,
  input wire logic TWO_WIRE_SCL_PULL_LOW,
  input wire logic SERIAL_PERIPH_ENABLE,
  input wire logic SERIAL_MASTER_SELECT,
  input wire logic SPI_MASTER_CLK_OUT,
  input wire logic TIMER0_CMP_B_OUT_EN,
  input wire logic TIMER0_CMP_B_OUT,
  input wire logic PIN_CHANGE_GRP0_EN,
  input wire logic [paf_pkg::PCI_SEL_W-1:0] PIN_CHANGE_SRC_SEL,
  input wire logic [paf_pkg::PA_W-1:0] ANALOG_DIGITAL_IN_DISABLE,
  // Port B pad inputs.
  input wire logic [paf_pkg::PB_W-1:0] PB_IN,
  // Inputs handed to the peripherals.
  output logic [paf_pkg::PA_W-1:0] PIN_CHANGE_GRP0_SRC,
  output logic [paf_pkg::PB_W-1:0] PIN_CHANGE_GRP1_SRC,
  output logic TIMER1_CAPTURE_IN,
  output logic TIMER1_COUNT_SRC,
  output logic SPI_CLK_IN,
  output logic SPI_SLAVE_SEL_IN,
  output logic TWO_WIRE_CLK_IN,
  output logic [paf_pkg::PA_W-1:0] ANALOG_CH_IN,
  output logic CMP_POS_IN,
  output logic CMP_NEG_IN,
  output logic TIMER0_COUNT_SRC,
  output logic EXT_CLOCK_IN,
  output logic PROG_SERIAL_CLK,
  output logic TWO_WIRE_DATA_IN,
  output logic SPI_MOSI_IN,
  output logic PROG_SERIAL_IO,
  output logic EXT_IRQ0_IN,
  output logic SPI_MISO_IN,
  output logic EXT_RESET_N_IN
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  paf_pkg::paf_state_s state; // All registered outputs.
  paf_pkg::paf_state_s next_state; // Their next values.
  paf_ovr_if ovr (); // Overrides toward the pin cells.
  logic spi_master; // SPI enabled as master.
  logic spi_slave; // SPI enabled as slave.
  logic [paf_pkg::PA_W-1:0] pci_grp0_sel; // Selected and enabled group 0 pins.
  logic scl_filtered; // Serial clock after the spike filter.

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Master and slave are exclusive, and both need the SPI enabled.
  assign spi_master = SERIAL_PERIPH_ENABLE & SERIAL_MASTER_SELECT;
  assign spi_slave = SERIAL_PERIPH_ENABLE & ~SERIAL_MASTER_SELECT;

  // A pin counts for group 0 only while its select and the group are on.
  assign pci_grp0_sel = PIN_CHANGE_SRC_SEL[paf_pkg::PA_W-1:0] &
                        {paf_pkg::PA_W{PIN_CHANGE_GRP0_EN}};

  // ----------------------------------------------------------------
  // Override generation
  // ----------------------------------------------------------------
  // Builds the override set of every pin. Bits 0 to 5 get none but the
  // input enable; bit 6 adds its direction; bit 7 carries the serial
  // clock, the SPI clock and the timer output.
  always_comb begin
    // Defaults leave every pin to the generic port logic.
    ovr.dir_override_en = paf_pkg::PA_RST;
    ovr.dir_override_val = paf_pkg::PA_RST;
    ovr.value_override_en = paf_pkg::PA_RST;
    ovr.value_override_val = paf_pkg::PA_RST;
    ovr.port_dir = PORTA_DIR;
    ovr.port_out = PORTA_OUT_REG;
    ovr.port_die = PORTA_NORMAL_DIG_IN_EN;

    // Input enable: forced on by pin change, forced off by the analog
    // disable bit when pin change does not claim the pin.
    ovr.digin_en_override_en = pci_grp0_sel | ANALOG_DIGITAL_IN_DISABLE;
    ovr.digin_en_override_val = pci_grp0_sel;

    // Slave select: SPI slave forces the pin to input.
    ovr.dir_override_en[paf_pkg::PA_SS_BIT] = spi_slave;
    // A master leaves the override off, so the register bit decides.
    ovr.dir_override_val[paf_pkg::PA_SS_BIT] = paf_pkg::BIT_RST;

    // Serial clock pin direction.
    if (TWO_WIRE_ENABLE) begin
      // Open drain: drive only while the two-wire logic pulls low.
      ovr.dir_override_en[paf_pkg::PA_SCK_BIT] = 1'b1;
      ovr.dir_override_val[paf_pkg::PA_SCK_BIT] = TWO_WIRE_SCL_PULL_LOW;
    end else if (spi_slave) begin
      // Slave clock input, whatever the direction bit says.
      ovr.dir_override_en[paf_pkg::PA_SCK_BIT] = 1'b1;
      ovr.dir_override_val[paf_pkg::PA_SCK_BIT] = paf_pkg::BIT_RST;
    end else begin
      // Master, timer output or plain port: direction register decides.
      ovr.dir_override_en[paf_pkg::PA_SCK_BIT] = paf_pkg::BIT_RST;
    end

    // Serial clock pin value override.
    ovr.value_override_en[paf_pkg::PA_SCK_BIT] = TWO_WIRE_ENABLE | spi_master |
                                                 TIMER0_CMP_B_OUT_EN;
    if (TWO_WIRE_ENABLE) begin
      // The open-drain driver only ever pulls low.
      ovr.value_override_val[paf_pkg::PA_SCK_BIT] = paf_pkg::PAD_LOW;
    end else if (spi_master) begin
      ovr.value_override_val[paf_pkg::PA_SCK_BIT] = SPI_MASTER_CLK_OUT;
    end else begin
      // The compare output shows only once software sets the direction bit.
      ovr.value_override_val[paf_pkg::PA_SCK_BIT] = TIMER0_CMP_B_OUT;
    end
  end

  // ----------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------
  // One cell per port A pin merges its overrides with the register bits.
  for (genvar i = 0; i < paf_pkg::PA_W; i++) begin : g_pin
    paf_pin_ovr #(
      .IDX(i)
    ) u_pin (
      .ovr(ovr)
    );
  end

  // ----------------------------------------------------------------
  // Serial clock spike filter
  // ----------------------------------------------------------------
  // Sits between the bit 7 pad level and the two-wire clock input,
  // active only while the two-wire interface is enabled.
  paf_spike_filter u_scl_filt (
    .clk(CORE_CLK),
    .rst(RST),
    .en(TWO_WIRE_ENABLE),
    .line_in(PA_IN[paf_pkg::PA_SCK_BIT]),
    .line_out(scl_filtered)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Gathers every output into the next state; pads and peripheral
  // inputs leave the block through one register stage, the two-wire clock through two.
  always_comb begin
    next_state = state;

    // Port A pad controls from the pin cells.
    next_state.pa_oe = ovr.res_oe;
    next_state.pa_out = ovr.res_val;
    next_state.pa_die = ovr.res_die;
    // Pull-up is never overridden, and no pin toggles its output bit.
    next_state.pa_pullup = PORTA_PULLUP_REG;
    // Slew limit and filter follow the two-wire enable on bit 7.
    next_state.pa7_slew_limit = TWO_WIRE_ENABLE;
    next_state.pa7_filt_en = TWO_WIRE_ENABLE;

    // Pin change sources: port A is group 0, port B is group 1.
    next_state.pci_grp0_src = PA_IN;
    next_state.pci_grp1_src = PB_IN;

    // Bit 7 digital input fans out to its peripherals.
    next_state.timer1_capture_in = PA_IN[paf_pkg::PA_SCK_BIT];
    next_state.timer1_count_src = PA_IN[paf_pkg::PA_SCK_BIT];
    next_state.spi_clk_in = PA_IN[paf_pkg::PA_SCK_BIT];
    next_state.two_wire_clk_in = scl_filtered;
    // Bit 6 digital input is the slave select.
    next_state.spi_slave_sel_in = PA_IN[paf_pkg::PA_SS_BIT];

    // Converter channels and comparator inputs.
    next_state.analog_ch = PA_IN;
    next_state.cmp_pos = PA_IN[paf_pkg::PA_CMP_POS_BIT];
    next_state.cmp_neg = PA_IN[paf_pkg::PA_CMP_NEG_BIT];

    // Port B bit 0: clock inputs.
    next_state.timer0_count_src = PB_IN[paf_pkg::PB_CLK_BIT];
    next_state.ext_clock_in = PB_IN[paf_pkg::PB_CLK_BIT];
    next_state.prog_serial_clk = PB_IN[paf_pkg::PB_CLK_BIT];
    // Port B bit 1: data inputs.
    next_state.two_wire_data_in = PB_IN[paf_pkg::PB_DATA_BIT];
    next_state.spi_mosi_in = PB_IN[paf_pkg::PB_DATA_BIT];
    next_state.prog_serial_io = PB_IN[paf_pkg::PB_DATA_BIT];
    // Port B bit 2: interrupt and master input.
    next_state.ext_irq0_in = PB_IN[paf_pkg::PB_IRQ_BIT];
    next_state.spi_miso_in = PB_IN[paf_pkg::PB_IRQ_BIT];
    // Port B bit 3: active-low external reset.
    next_state.ext_reset_n_in = PB_IN[paf_pkg::PB_RST_BIT];
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset releases every pad and parks the two-wire, slave select and reset lines high.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state.pa_out <= paf_pkg::PA_RST;
      state.pa_oe <= paf_pkg::PA_RST;
      state.pa_pullup <= paf_pkg::PA_RST;
      state.pa_die <= paf_pkg::PA_RST;
      state.pa7_slew_limit <= paf_pkg::BIT_RST;
      state.pa7_filt_en <= paf_pkg::BIT_RST;
      state.pci_grp0_src <= paf_pkg::PA_RST;
      state.pci_grp1_src <= paf_pkg::PB_RST;
      state.timer1_capture_in <= paf_pkg::BIT_RST;
      state.timer1_count_src <= paf_pkg::BIT_RST;
      state.spi_clk_in <= paf_pkg::BIT_RST;
      state.spi_slave_sel_in <= paf_pkg::LINE_IDLE;
      state.two_wire_clk_in <= paf_pkg::LINE_IDLE;
      state.analog_ch <= paf_pkg::PA_RST;
      state.cmp_pos <= paf_pkg::BIT_RST;
      state.cmp_neg <= paf_pkg::BIT_RST;
      state.timer0_count_src <= paf_pkg::BIT_RST;
      state.ext_clock_in <= paf_pkg::BIT_RST;
      state.prog_serial_clk <= paf_pkg::BIT_RST;
      state.two_wire_data_in <= paf_pkg::LINE_IDLE;
      state.spi_mosi_in <= paf_pkg::BIT_RST;
      state.prog_serial_io <= paf_pkg::BIT_RST;
      state.ext_irq0_in <= paf_pkg::BIT_RST;
      state.spi_miso_in <= paf_pkg::BIT_RST;
      state.ext_reset_n_in <= paf_pkg::LINE_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign PA_OUT = state.pa_out;
  assign PA_OE = state.pa_oe;
  assign PA_PULLUP_EN = state.pa_pullup;
  assign PA_DIG_IN_EN = state.pa_die;
  assign PA7_SLEW_LIMIT_EN = state.pa7_slew_limit;
  assign PA7_SPIKE_FILT_EN = state.pa7_filt_en;
  assign PIN_CHANGE_GRP0_SRC = state.pci_grp0_src;
  assign PIN_CHANGE_GRP1_SRC = state.pci_grp1_src;
  assign TIMER1_CAPTURE_IN = state.timer1_capture_in;
  assign TIMER1_COUNT_SRC = state.timer1_count_src;
  assign SPI_CLK_IN = state.spi_clk_in;
  assign SPI_SLAVE_SEL_IN = state.spi_slave_sel_in;
  assign TWO_WIRE_CLK_IN = state.two_wire_clk_in;
  assign ANALOG_CH_IN = state.analog_ch;
  assign CMP_POS_IN = state.cmp_pos;
  assign CMP_NEG_IN = state.cmp_neg;
  assign TIMER0_COUNT_SRC = state.timer0_count_src;
  assign EXT_CLOCK_IN = state.ext_clock_in;
  assign PROG_SERIAL_CLK = state.prog_serial_clk;
  assign TWO_WIRE_DATA_IN = state.two_wire_data_in;
  assign SPI_MOSI_IN = state.spi_mosi_in;
  assign PROG_SERIAL_IO = state.prog_serial_io;
  assign EXT_IRQ0_IN = state.ext_irq0_in;
  assign SPI_MISO_IN = state.spi_miso_in;
  assign EXT_RESET_N_IN = state.ext_reset_n_in;

endmodule : port_alt_function_override

// file: rtl/paf_pkg.sv
/*
  Shared constants and state types of the port A alternate-function override block.
  Assumes a single 100 MHz core clock and a synchronous active-high reset.
*/
package paf_pkg;

  // ----------------------------------------------------------------
  // Widths and pin positions
  // ----------------------------------------------------------------
  localparam int PA_W = 8; // Port A width.
  localparam int PB_W = 4; // Port B width.
  localparam int PCI_SEL_W = 12; // Pin-change source selects, both groups.
  localparam int PCI1_BASE = 8; // Source index of port B bit 0.
  localparam int PA_SCK_BIT = 7; // Serial clock, timer and capture pin.
  localparam int PA_SS_BIT = 6; // Slave select pin.
  localparam int PA_CMP_POS_BIT = 1; // Comparator positive input pin.
  localparam int PA_CMP_NEG_BIT = 2; // Comparator negative input pin.
  localparam int PB_CLK_BIT = 0; // Timer 0 clock, external clock, programming clock.
  localparam int PB_DATA_BIT = 1; // Two-wire data, MOSI, programming data.
  localparam int PB_IRQ_BIT = 2; // External interrupt 0 and MISO.
  localparam int PB_RST_BIT = 3; // External reset input.

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [PA_W-1:0] PA_RST = 8'h00; // Pins released, inputs low.
  localparam logic [PB_W-1:0] PB_RST = 4'h0; // Port B samples low.
  localparam logic BIT_RST = 1'b0; // Single-bit samples and enables.
  localparam logic LINE_IDLE = 1'b1; // Idle level of clock and reset lines.
  localparam logic PAD_LOW = 1'b0; // Value driven by an open-drain pull.

  // ----------------------------------------------------------------
  // Timing of the serial clock spike filter
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100; // Core clock rate.
  localparam int SPIKE_FILT_NS = 50; // Shortest pulse that passes the filter.
  localparam int SPIKE_FILT_CYCLES = (SPIKE_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_CNT_W = 3; // Wide enough for the cycle count.
  localparam logic [FILT_CNT_W-1:0] FILT_CNT_RST = 3'h0;
  localparam logic [FILT_CNT_W-1:0] FILT_CNT_STEP = 3'h1;
  localparam logic [FILT_CNT_W-1:0] FILT_LAST = FILT_CNT_W'(SPIKE_FILT_CYCLES - 1);

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  // State of the spike filter.
  typedef struct packed {
    logic [FILT_CNT_W-1:0] cnt; // Consecutive samples that differ from level.
    logic level; // Filtered line level.
  } paf_filt_s;

  // State of the top module: every registered output.
  typedef struct packed {
    logic [PA_W-1:0] pa_out;
    logic [PA_W-1:0] pa_oe;
    logic [PA_W-1:0] pa_pullup;
    logic [PA_W-1:0] pa_die;
    logic pa7_slew_limit;
    logic pa7_filt_en;
    logic [PA_W-1:0] pci_grp0_src;
    logic [PB_W-1:0] pci_grp1_src;
    logic timer1_capture_in;
    logic timer1_count_src;
    logic spi_clk_in;
    logic spi_slave_sel_in;
    logic two_wire_clk_in;
    logic [PA_W-1:0] analog_ch;
    logic cmp_pos;
    logic cmp_neg;
    logic timer0_count_src;
    logic ext_clock_in;
    logic prog_serial_clk;
    logic two_wire_data_in;
    logic spi_mosi_in;
    logic prog_serial_io;
    logic ext_irq0_in;
    logic spi_miso_in;
    logic ext_reset_n_in;
  } paf_state_s;

endpackage : paf_pkg

// file: rtl/paf_ovr_if.sv
/*
  Interface carrying the per-pin override signals of port A and their results.
  Assumes the control side drives the overrides and the pin cells return results.
*/
`timescale 1ns/10ps
interface paf_ovr_if;
  logic [paf_pkg::PA_W-1:0] dir_override_en; // Direction taken from override.
  logic [paf_pkg::PA_W-1:0] dir_override_val; // Override driver enable.
  logic [paf_pkg::PA_W-1:0] value_override_en; // Value taken from override.
  logic [paf_pkg::PA_W-1:0] value_override_val; // Override pin value.
  logic [paf_pkg::PA_W-1:0] digin_en_override_en; // Input enable taken from override.
  logic [paf_pkg::PA_W-1:0] digin_en_override_val; // Override input enable.
  logic [paf_pkg::PA_W-1:0] port_dir; // Data-direction register bits.
  logic [paf_pkg::PA_W-1:0] port_out; // Port output register bits.
  logic [paf_pkg::PA_W-1:0] port_die; // Input enable from the core state.
  logic [paf_pkg::PA_W-1:0] res_oe; // Resulting driver enable.
  logic [paf_pkg::PA_W-1:0] res_val; // Resulting pin value.
  logic [paf_pkg::PA_W-1:0] res_die; // Resulting input enable.

  // Control side: sets overrides, reads results.
  modport ctrl (
    output dir_override_en,
    output dir_override_val,
    output value_override_en,
    output value_override_val,
    output digin_en_override_en,
    output digin_en_override_val,
    output port_dir,
    output port_out,
    output port_die,
    input res_oe,
    input res_val,
    input res_die
  );

  // Pin cell side: reads overrides, returns results.
  modport pin (
    input dir_override_en,
    input dir_override_val,
    input value_override_en,
    input value_override_val,
    input digin_en_override_en,
    input digin_en_override_val,
    input port_dir,
    input port_out,
    input port_die,
    output res_oe,
    output res_val,
    output res_die
  );
endinterface : paf_ovr_if

// file: rtl/paf_pin_ovr.sv
/*
  One port A pin cell: merges overrides with the port register bits.
  Assumes the interface bit IDX belongs to this cell alone.
*/
`timescale 1ns/10ps
module paf_pin_ovr #(
  parameter int IDX = 0
) (
  paf_ovr_if.pin ovr
);

  // ----------------------------------------------------------------
  // Override merge
  // ----------------------------------------------------------------
  // Driver enable follows the override value when the override is on.
  assign ovr.res_oe[IDX] = ovr.dir_override_en[IDX] ? ovr.dir_override_val[IDX] :
                           ovr.port_dir[IDX];
  // Pin value follows the override value instead of the output register bit.
  assign ovr.res_val[IDX] = ovr.value_override_en[IDX] ? ovr.value_override_val[IDX] :
                            ovr.port_out[IDX];
  // Input enable follows the override value instead of the core state.
  assign ovr.res_die[IDX] = ovr.digin_en_override_en[IDX] ?
                            ovr.digin_en_override_val[IDX] : ovr.port_die[IDX];

endmodule : paf_pin_ovr

// file: rtl/paf_spike_filter.sv
/*
  Spike filter on the serial clock line between pad and two-wire logic.
  Assumes its input is already synchronous to the clock.
*/
`timescale 1ns/10ps
module paf_spike_filter (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic line_in,
  output logic line_out
);

  paf_pkg::paf_filt_s state; // Registered state.
  paf_pkg::paf_filt_s next_state; // Next state.

  // ----------------------------------------------------------------
  // Filter logic
  // ----------------------------------------------------------------
  // A level change passes only after it has held for the full count;
  // shorter pulses reset the count and never reach the output.
  always_comb begin
    next_state = state;
    if (!en) begin
      // Bypassed: the line passes straight through.
      next_state.level = line_in;
      next_state.cnt = paf_pkg::FILT_CNT_RST;
    end else if (line_in == state.level) begin
      // No difference: forget any partial pulse.
      next_state.cnt = paf_pkg::FILT_CNT_RST;
    end else if (state.cnt == paf_pkg::FILT_LAST) begin
      // Pulse long enough: accept the new level.
      next_state.level = line_in;
      next_state.cnt = paf_pkg::FILT_CNT_RST;
    end else begin
      next_state.cnt = state.cnt + paf_pkg::FILT_CNT_STEP;
    end
  end

  // Registers the filter state.
  always_ff @(posedge clk) begin
    if (rst) begin
      state.cnt <= paf_pkg::FILT_CNT_RST;
      state.level <= paf_pkg::LINE_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign line_out = state.level;

endmodule : paf_spike_filter

// file: tb/paf_chk_sva.sv
/* Checker of the port A override block, bound to its top.
   Sees the top ports only; one clock, synchronous reset. */
`timescale 1ns/10ps
module paf_chk_sva (
  input wire logic CORE_CLK, RST, TWO_WIRE_ENABLE, TWO_WIRE_SCL_PULL_LOW,
  input wire logic SERIAL_PERIPH_ENABLE, SERIAL_MASTER_SELECT, SPI_MASTER_CLK_OUT,
  input wire logic TIMER0_CMP_B_OUT_EN, TIMER0_CMP_B_OUT, PIN_CHANGE_GRP0_EN,
  input wire logic PA7_SPIKE_FILT_EN, TWO_WIRE_CLK_IN,
  input wire logic [7:0] PORTA_DIR, PORTA_OUT_REG, PORTA_NORMAL_DIG_IN_EN, PA_IN,
  input wire logic [7:0] PA_OUT, PA_OE, PA_DIG_IN_EN, ANALOG_DIGITAL_IN_DISABLE,
  input wire logic [7:0] PORTA_PULLUP_REG, PA_PULLUP_EN, PIN_CHANGE_GRP0_SRC,
  input wire logic [11:0] PIN_CHANGE_SRC_SEL,
  input wire logic [3:0] PB_IN, PIN_CHANGE_GRP1_SRC
);
  logic up; // Outputs track inputs from the second edge after release.
  logic tw, mst, slv; // Mode shorthands.
  logic [7:0] die; // Expected input enable of the cycle.
  always_ff @(posedge CORE_CLK) up <= !RST;
  assign tw = TWO_WIRE_ENABLE;
  assign mst = SERIAL_PERIPH_ENABLE & SERIAL_MASTER_SELECT;
  assign slv = SERIAL_PERIPH_ENABLE & ~SERIAL_MASTER_SELECT;
  assign die = PIN_CHANGE_SRC_SEL[7:0] & {8{PIN_CHANGE_GRP0_EN}}
    | ~ANALOG_DIGITAL_IN_DISABLE & PORTA_NORMAL_DIG_IN_EN;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // Five low samples of the clock pad with the filter on.
  sequence lo5; (tw && !PA_IN[7]) [*5]; endsequence
  grp0_src_a: assert property (up |-> PIN_CHANGE_GRP0_SRC == $past(PA_IN))
    else $error("group 0 source wrong");
  grp1_src_a: assert property (up |-> PIN_CHANGE_GRP1_SRC == $past(PB_IN))
    else $error("group 1 source wrong");
  die_ovr_a: assert property (up |-> PA_DIG_IN_EN == $past(die))
    else $error("input enable wrong");
  scl_od_a: assert property (up && $past(tw) |-> !PA_OUT[7] && PA7_SPIKE_FILT_EN
    && PA_OE[7] == $past(TWO_WIRE_SCL_PULL_LOW)) else $error("clock not open drain");
  slave_in_a: assert property (up && $past(slv && !tw) |-> PA_OE[7:6] == 2'b00)
    else $error("slave pins driven");
  master_pins_a: assert property (up && $past(mst && !tw)
    |-> PA_OE[7:6] == $past(PORTA_DIR[7:6]) && PA_OUT[7] == $past(SPI_MASTER_CLK_OUT))
    else $error("master pins wrong");
  cmp_b_a: assert property (up && $past(!tw && !mst && TIMER0_CMP_B_OUT_EN)
    |-> PA_OUT[7] == $past(TIMER0_CMP_B_OUT)) else $error("compare output wrong");
  low_pins_a: assert property (up |-> PA_OE[5:0] == $past(PORTA_DIR[5:0])
    && PA_OUT[6:0] == $past(PORTA_OUT_REG[6:0]) && PA_PULLUP_EN == $past(PORTA_PULLUP_REG))
    else $error("plain pin overridden");
  spike_filt_a: assert property (lo5 |-> ##2 !TWO_WIRE_CLK_IN) else $error("filter stuck");
endmodule : paf_chk_sva
bind port_alt_function_override paf_chk_sva chk_u (.*);

// file: tb/paf_pad_model.sv
/* Pads of port A with the world outside them.
   The block wins where it drives; else outside driver, pull-up, or a float. */
`timescale 1ns/10ps
module paf_pad_model (
  input wire logic clk,
  input wire logic [7:0] oe, val, pull, ext_en, ext,
  output logic [7:0] pad
);
  logic tog = 1'b0; // A floating pin changes every cycle.
  always @(negedge clk) tog <= !tog;
  assign pad = oe & val | ~oe & (ext_en & ext | ~ext_en & (pull | {8{tog}}));
endmodule : paf_pad_model

// file: tb/test_port_alt_function_override.sv
/* Self-checking bench of the port A override block.
   Inputs change at the falling edge; outputs are read there too. */
`timescale 1ns/10ps
module test_port_alt_function_override;
  logic CORE_CLK = 1'b0, RST = 1'b1, tw = 1'b0, pl = 1'b0, serial_periph_enable = 1'b0, ms = 1'b0;
  logic sck = 1'b0, ce = 1'b0, cv = 1'b0, ge = 1'b0, slew, filt;
  logic [7:0] dir = 8'h00, oreg = 8'h00, pu = 8'h0F, nde = 8'hFF, dis = 8'h00;
  logic [7:0] xv = 8'h00, pa, po, poe, ppu, die, g0, an, ra, rb;
  logic [11:0] sel = 12'h000;
  logic [3:0] pb = 4'h0, g1;
  int bad_count = 0, compares = 0, cyc = 0;
  initial forever #5 CORE_CLK = ~CORE_CLK;
  paf_pad_model pad_u (.clk(CORE_CLK), .oe(poe), .val(po), .pull(ppu), .ext_en(8'hFF),
    .ext(xv), .pad(pa));
  port_alt_function_override dut_u (.CORE_CLK(CORE_CLK), .RST(RST), .PORTA_DIR(dir),
    .PORTA_OUT_REG(oreg), .PORTA_PULLUP_REG(pu), .PORTA_NORMAL_DIG_IN_EN(nde), .PA_IN(pa),
    .PA_OUT(po), .PA_OE(poe), .PA_PULLUP_EN(ppu), .PA_DIG_IN_EN(die), .PA7_SLEW_LIMIT_EN(slew),
    .PA7_SPIKE_FILT_EN(filt), .TWO_WIRE_ENABLE(tw), .TWO_WIRE_SCL_PULL_LOW(pl),
    .SERIAL_PERIPH_ENABLE(serial_periph_enable), .SERIAL_MASTER_SELECT(ms), .SPI_MASTER_CLK_OUT(sck),
    .TIMER0_CMP_B_OUT_EN(ce), .TIMER0_CMP_B_OUT(cv), .PIN_CHANGE_GRP0_EN(ge),
    .PIN_CHANGE_SRC_SEL(sel), .ANALOG_DIGITAL_IN_DISABLE(dis), .PB_IN(pb),
    .PIN_CHANGE_GRP0_SRC(g0), .PIN_CHANGE_GRP1_SRC(g1), .TIMER1_CAPTURE_IN(ra[7]),
    .TIMER1_COUNT_SRC(ra[6]), .SPI_CLK_IN(ra[5]), .SPI_SLAVE_SEL_IN(ra[4]),
    .ANALOG_CH_IN(an), .CMP_POS_IN(ra[3]), .CMP_NEG_IN(ra[2]), .EXT_CLOCK_IN(ra[1]),
    .EXT_IRQ0_IN(ra[0]), .TIMER0_COUNT_SRC(rb[7]), .PROG_SERIAL_CLK(rb[6]),
    .TWO_WIRE_DATA_IN(rb[5]), .SPI_MOSI_IN(rb[4]), .PROG_SERIAL_IO(rb[3]),
    .SPI_MISO_IN(rb[2]), .EXT_RESET_N_IN(rb[1]), .TWO_WIRE_CLK_IN(rb[0]));
  task automatic step(input int n);
    repeat (n) @(negedge CORE_CLK);
  endtask : step
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run;
    if (bad_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // A hang is cut short well beyond the length of the sequence.
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 600) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    step(4);
    chk(ra, 8'h10);
    chk(rb, 8'h23);
    RST = 1'b0;
    dir = 8'hFF; oreg = 8'hA5; serial_periph_enable = 1'b1; step(2);
    chk(poe, 8'h3F);
    chk(po, 8'hA5);
    ms = 1'b1; dir = 8'h7F; oreg = 8'h25; sck = 1'b1; step(2);
    chk(poe, 8'h7F);
    chk(po, 8'hA5);
    serial_periph_enable = 1'b0; dir = 8'hFF; ce = 1'b1; oreg = 8'hA5; step(2);
    chk(po, 8'h25);
    chk(poe, 8'hFF);
    cv = 1'b1;
    step(2);
    chk(po, 8'hA5);
    tw = 1'b1; pl = 1'b1; step(2);
    chk({slew, filt, pa[7], po[7], 4'h0}, 8'hC0);
    pl = 1'b0; xv = 8'hFF; step(8);
    chk(poe, 8'h7F);
    // A low pulse of four samples on the clock pad must vanish.
    for (int i = 0; i < 12; i++) begin
      xv[7] = (i > 3); step(1);
      chk({7'h00, rb[0]}, 8'h01);
    end
    xv[7] = 1'b0; step(6);
    chk({7'h00, rb[0]}, 8'h00);
    tw = 1'b0; ce = 1'b0; dis = 8'h0F; sel = 12'hAF3; ge = 1'b1; step(2);
    chk(die, 8'hF3);
    chk(po, 8'hA5);
    ge = 1'b0; nde = 8'h5A; step(2);
    chk(die, 8'h50);
    dir = 8'h00; xv = 8'h96; pb = 4'h6; step(4);
    chk(g0, 8'h96);
    chk(an, 8'h96);
    chk({4'h0, g1}, 8'h06);
    chk(ra, 8'hED);
    chk(rb, 8'h3D);
    chk(ppu, 8'h0F);
    complete_run();
  end
endmodule : test_port_alt_function_override
